//--- design/psi_pkg.sv
// Package for the PHY status summary and interrupt control block.
// Assumes one 25 MHz clock and a 32-bit AXI4-Lite register bus.

package psi_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [5:0] IDX_SUMMARY = 6'h10;  // Status summary
  localparam logic [5:0] IDX_CONTROL = 6'h11;  // Interrupt control
  localparam logic [5:0] IDX_EVENT   = 6'h12;  // Event status and enables
  localparam int unsigned ADDR_W     = 8;      // Byte address width

  // ==========================================================
  // Status summary fields
  localparam int unsigned SUM_LINK = 0;   // Link mirror
  localparam int unsigned SUM_SPD  = 1;   // One is 10 Mb/s
  localparam int unsigned SUM_DUP  = 2;   // One is full duplex
  localparam int unsigned SUM_ANC  = 4;   // Negotiation complete
  localparam int unsigned SUM_PEND = 7;   // Interrupt pending

  // ==========================================================
  // Interrupt control fields
  localparam int unsigned CTL_W      = 3;             // Implemented bits
  localparam int unsigned CTL_INT_OE = 0;             // Pin is irq output
  localparam int unsigned CTL_EV_EN  = 1;             // Event irq enable
  localparam int unsigned CTL_TEST   = 2;             // Forced test irq
  localparam logic [2:0]  CTL_RESET  = 3'h0;          // Reset value

  // ==========================================================
  // Event register: status in [15:9], enables in [6:0]
  localparam int unsigned EV_COUNT  = 7;
  localparam int unsigned EV_LSB    = 9;
  localparam int unsigned EV_CTR    = 0;  // Counter half full
  localparam int unsigned EV_ANC    = 1;  // Negotiation complete
  localparam int unsigned EV_DUP    = 2;  // Duplex change
  localparam int unsigned EV_SPD    = 3;  // Speed change
  localparam int unsigned EV_LINK   = 4;  // Link change
  localparam int unsigned EV_ENERGY = 5;  // Energy detect change
  localparam int unsigned EV_LQ     = 6;  // Link quality monitor
  localparam logic [6:0]  EN_RESET  = 7'h00;

  // ==========================================================
  // Bus responses and decode results
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {SEL_NONE, SEL_SUM, SEL_CTL, SEL_EVT} psi_sel_e;

  // ==========================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } psi_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } psi_axil_rsp_s;

endpackage

//--- design/psi_event_latch.sv
// Sticky event status bits, cleared by a read of their register.
// Assumes event pulses and the clear strobe come from the same clock.
`timescale 1ns/100ps
`default_nettype none

module psi_event_latch #(
  parameter int unsigned N = 7
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Event pulses and read clear
  input  wire logic [N-1:0] ev,
  input  wire logic         clr,
  // Latched status
  output var  logic [N-1:0] status_r
);

  // ==========================================================
  // One flop per event
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      // Set beats clear so an event during the read is kept
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          status_r[i] <= 1'b0;
        else if (ev[i])
          status_r[i] <= 1'b1;  // [RQ12]
        else if (clr)
          status_r[i] <= 1'b0;  // [RQ12]
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  property p_ev_latch;
    @(posedge clock) disable iff (rst)
    (|ev) |=> ((status_r & $past(ev)) == $past(ev));
  endproperty
  a_ev_latch: assert property (p_ev_latch) else $error("event not latched");  // [RQ12]

  property p_ev_clear;
    @(posedge clock) disable iff (rst)
    (clr && ev == '0) |=> (status_r == '0);
  endproperty
  a_ev_clear: assert property (p_ev_clear) else $error("read did not clear status");  // [RQ12]

endmodule // psi_event_latch

`default_nettype wire

//--- design/psi_top.sv
// PHY status summary and interrupt control, AXI4-Lite slave.
// Assumes line status and event pulses come from logic on this clock;
// only the shared pin input is asynchronous.
//
// Functional notes
// [RQ1] Summary bit 2 shows full duplex
// [RQ2] Summary bit 1 shows 10 Mb/s speed
// [RQ3] Software trusts speed/duplex only with link
// [RQ4] Summary bit 0 mirrors link, read keeps it
// [RQ5] Link bit one when link at 10/100
// [RQ6] Control bits 15:3 ignore writes, read zero
// [RQ7] Test bit forces interrupt until cleared
// [RQ8] Global enable gates all event interrupts
// [RQ9] Control bit 0 selects pin role
// [RQ10] Seven event sources feed the interrupt
// [RQ11] Software sets per-event enables plus global enable
// [RQ12] Events latch always; register read clears them
// [RQ13] Summary bit 7 pending; event read clears
// [RQ14] Pin driven low while interrupt pending
`timescale 1ns/100ps
`default_nettype none

module psi_top
  import psi_pkg::*;
#(
  parameter int unsigned NUM_EV = EV_COUNT
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Register bus
  input  wire psi_axil_req_s axil_req,
  output var  psi_axil_rsp_s axil_rsp,
  // Resolved line status
  input  wire logic          link_up,
  input  wire logic          duplex_full,
  input  wire logic          speed_10,
  input  wire logic          an_complete,
  // Event pulses from monitors
  input  wire logic          lq_evt,
  input  wire logic          energy_evt,
  input  wire logic          ctr_half_evt,
  // Shared power-down or interrupt pin
  input  wire logic          pin_i,
  output var  logic          pin_o,
  output var  logic          pin_oe,
  // Interrupt and power-down request
  output var  logic          irq,
  output var  logic          powerdown
);

  // ==========================================================
  // Address decode, used for both reads and writes
  function automatic psi_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    case (a[ADDR_W-1:2])
      IDX_SUMMARY: reg_sel = SEL_SUM;
      IDX_CONTROL: reg_sel = SEL_CTL;
      IDX_EVENT:   reg_sel = SEL_EVT;
      default:     reg_sel = SEL_NONE;
    endcase
  endfunction

  // ==========================================================
  // Declarations
  logic [CTL_W-1:0]  ctrl_r;       // Control bits
  logic [NUM_EV-1:0] en_r;         // Per-event enables
  logic [NUM_EV-1:0] ev_status;    // Latched events
  logic [NUM_EV-1:0] ev;           // Event pulses this cycle
  logic              link_q;       // Previous line status
  logic              spd_q;
  logic              dup_q;
  logic              anc_q;
  logic              pin_s1_r;     // Pin synchroniser
  logic              pin_s2_r;
  logic              pending;      // Interrupt pending
  logic              evt_clr;      // Read of event register
  logic              aw_full_r;    // Write address held
  logic              w_full_r;     // Write data held
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              ar_hs;        // Read address taken
  logic              wr_go;        // Write performed
  psi_sel_e          wsel;
  psi_sel_e          rsel;
  logic [31:0]       rd_mux;

  assign ar_hs   = axil_req.arvalid & arready_r;
  assign wr_go   = aw_full_r & w_full_r & ~bvalid_r;
  assign wsel    = reg_sel(awaddr_r);
  assign rsel    = reg_sel(axil_req.araddr);
  assign evt_clr = ar_hs & (rsel == SEL_EVT);  // [RQ12] [RQ13]

  // ==========================================================
  // Event sources
  // Edge detect on resolved status, seen one cycle after change
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      link_q <= 1'b0;
      spd_q  <= 1'b0;
      dup_q  <= 1'b0;
      anc_q  <= 1'b0;
    end
    else
    begin
      link_q <= link_up;
      spd_q  <= speed_10;
      dup_q  <= duplex_full;
      anc_q  <= an_complete;
    end
  end

  // Seven sources in event-register order
  always_comb
  begin
    ev            = '0;
    ev[EV_CTR]    = ctr_half_evt;               // [RQ10]
    ev[EV_ANC]    = an_complete & ~anc_q;       // [RQ10]
    ev[EV_DUP]    = duplex_full ^ dup_q;        // [RQ10]
    ev[EV_SPD]    = speed_10 ^ spd_q;           // [RQ10]
    ev[EV_LINK]   = link_up ^ link_q;           // [RQ10]
    ev[EV_ENERGY] = energy_evt;                 // [RQ10]
    ev[EV_LQ]     = lq_evt;                     // [RQ10]
  end

  // Sticky status, latched even when disabled
  psi_event_latch #(
    .N        (NUM_EV)
  ) u_latch (
    .clock    (clock),
    .rst      (rst),
    .ev       (ev),
    .clr      (evt_clr),
    .status_r (ev_status)
  );

  // ==========================================================
  // Interrupt decision
  // Test bit bypasses the global enable on purpose
  assign pending = ctrl_r[CTL_TEST]                                    // [RQ7]
                 | (ctrl_r[CTL_EV_EN] & (|(ev_status & en_r)));        // [RQ8]

  // Registered outputs; pin drive only in output role
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq    <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      irq    <= pending;                          // [RQ7] [RQ8]
      pin_oe <= ctrl_r[CTL_INT_OE] & pending;     // [RQ9] [RQ14]
    end
  end

  // Open-drain style: only ever pulls low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pin_o <= 1'b0;
    else
      pin_o <= 1'b0;  // [RQ14]
  end

  // ==========================================================
  // Power-down input path
  // Two flops before use; pin idles high when released
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Low pin requests power-down only in input role
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      powerdown <= 1'b0;
    else
      powerdown <= ~ctrl_r[CTL_INT_OE] & ~pin_s2_r;  // [RQ9]
  end

  // ==========================================================
  // Write channel: address and data taken in either order
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_full_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r  <= '0;
    end
    else if (axil_req.awvalid && awready_r)
    begin
      aw_full_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r  <= axil_req.awaddr;
    end
    else if (wr_go)
      aw_full_r <= 1'b0;
    else if (bvalid_r && axil_req.bready)
      awready_r <= 1'b1;  // One write at a time
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      w_full_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end
    else if (axil_req.wvalid && wready_r)
    begin
      w_full_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r  <= axil_req.wdata;
      wstrb_r  <= axil_req.wstrb;
    end
    else if (wr_go)
      w_full_r <= 1'b0;
    else if (bvalid_r && axil_req.bready)
      wready_r <= 1'b1;
  end

  // Write response; unmapped gets an error
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bvalid_r && axil_req.bready)
      bvalid_r <= 1'b0;
  end

  // Control and enable bits; only the low byte lane holds them
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= CTL_RESET;
      en_r   <= EN_RESET;
    end
    else if (wr_go && wstrb_r[0])
    begin
      if (wsel == SEL_CTL)
        ctrl_r <= wdata_r[CTL_W-1:0];  // [RQ6] upper bits dropped
      else if (wsel == SEL_EVT)
        en_r <= wdata_r[NUM_EV-1:0];   // Status bits are read-only
    end
  end

  // ==========================================================
  // Read channel
  always_comb
  begin
    rd_mux = '0;
    case (rsel)
      SEL_SUM:
      begin
        rd_mux[SUM_LINK] = link_up;       // [RQ4] [RQ5]
        rd_mux[SUM_SPD]  = speed_10;      // [RQ2]
        rd_mux[SUM_DUP]  = duplex_full;   // [RQ1]
        rd_mux[SUM_ANC]  = an_complete;
        rd_mux[SUM_PEND] = pending;       // [RQ13]
      end
      SEL_CTL: rd_mux[CTL_W-1:0] = ctrl_r;  // [RQ6]
      SEL_EVT:
      begin
        rd_mux[EV_LSB +: NUM_EV] = ev_status;
        rd_mux[NUM_EV-1:0]       = en_r;
      end
      default: rd_mux = '0;
    endcase
  end

  // Data captured at the address edge, with the clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid_r && axil_req.rready)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign axil_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                      bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                      rdata: rdata_r, rresp: rresp_r};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_dup_bit;
    (ar_hs && rsel == SEL_SUM) |=> (rdata_r[SUM_DUP] == $past(duplex_full));
  endproperty
  a_dup_bit: assert property (p_dup_bit) else $error("duplex bit wrong");  // [RQ1]

  property p_spd_bit;
    (ar_hs && rsel == SEL_SUM) |=> (rdata_r[SUM_SPD] == $past(speed_10));
  endproperty
  a_spd_bit: assert property (p_spd_bit) else $error("speed bit wrong");  // [RQ2]

  property p_link_bit;
    (ar_hs && rsel == SEL_SUM) |=> (rdata_r[SUM_LINK] == $past(link_up));
  endproperty
  a_link_bit: assert property (p_link_bit) else $error("link copy lost");  // [RQ4]

  property p_link_zero;
    (ar_hs && rsel == SEL_SUM && !link_up) |=> rvalid_r && !rdata_r[SUM_LINK];
  endproperty
  a_link_zero: assert property (p_link_zero) else $error("link bit without link");  // [RQ5]

  property p_ctl_rsvd;
    (ar_hs && rsel == SEL_CTL) |=> (rdata_r[31:CTL_W] == '0);
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved bits not zero");  // [RQ6]

  property p_test_irq;
    ctrl_r[CTL_TEST] [*2] |=> irq;
  endproperty
  a_test_irq: assert property (p_test_irq) else $error("test interrupt missing");  // [RQ7]

  property p_gate;
    (!ctrl_r[CTL_EV_EN] && !ctrl_r[CTL_TEST]) |=> !irq;
  endproperty
  a_gate: assert property (p_gate) else $error("event irq while disabled");  // [RQ8]

  property p_pin_in;
    !ctrl_r[CTL_INT_OE] |=> !pin_oe;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("pin driven as input");  // [RQ9]

  property p_link_evt;
    $changed(link_up) |=> ev_status[EV_LINK];
  endproperty
  a_link_evt: assert property (p_link_evt) else $error("link event lost");  // [RQ10]

  property p_pend_clr;
    (evt_clr && !ctrl_r[CTL_TEST] && ev == '0) |=> !pending ##1 !irq;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");  // [RQ13]

  property p_pin_drive;
    (ctrl_r[CTL_INT_OE] && pending) |=> (pin_oe && !pin_o);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not pulled low");  // [RQ14]

  property p_cov_test;
    ctrl_r[CTL_TEST] ##1 irq;
  endproperty
  c_cov_test: cover property (p_cov_test);

  property p_cov_clr;
    (irq && evt_clr) ##2 !irq;
  endproperty
  c_cov_clr: cover property (p_cov_clr);

  property p_cov_pd;
    powerdown ##1 !powerdown;
  endproperty
  c_cov_pd: cover property (p_cov_pd);

endmodule // psi_top

`default_nettype wire

//--- tb/psi_host_model.sv
// Host side of the shared pin: pull-up, power-down driver, irq input.
// Assumes the device pin drive comes from the same clock as the host.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Host pin model
module psi_host_model (
  // Clock
  input  wire logic clock,
  // Device pin drive
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Host power-down request
  input  wire logic pd_req,
  // Pad level and host interrupt view
  output var  logic pin_i,
  output var  logic irq_seen
);
  // Pad level: device drive wins, then host, then pull-up
  always_comb
  begin
    if (pin_oe)
      pin_i = pin_o;  // Device owns the pad as irq output
    else if (pd_req)
      pin_i = 1'b0;   // Host asks for power-down, active low
    else
      pin_i = 1'b1;   // Released pad floats high on the pull-up
  end

  // Host interrupt input is active low, sampled each edge
  always_ff @(posedge clock)
    irq_seen <= ~pin_i;
endmodule // psi_host_model

`default_nettype wire

//--- tb/tb_phy_status_irq_control.sv
// Self-checking bench for the status summary and interrupt control block.
// Assumes psi_pkg and psi_top are compiled first; one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_phy_status_irq_control
  import psi_pkg::*;
;
  // ==========================================================
  // Signals
  logic          clock = 1'b0;           // 25 MHz
  logic          rst = 1'b1;             // Async reset, high
  psi_axil_req_s req = '0;               // Bus master side
  psi_axil_rsp_s rsp;                    // Bus slave side
  logic          link_up = 1'b0;         // Line status
  logic          duplex_full = 1'b0;
  logic          speed_10 = 1'b0;
  logic          an_complete = 1'b0;
  logic          lq_evt = 1'b0;          // Event pulses
  logic          energy_evt = 1'b0;
  logic          ctr_half_evt = 1'b0;
  logic          pd_req = 1'b0;          // Host power-down request
  logic          pin_i, pin_o, pin_oe;   // Shared pin
  logic          irq, powerdown, irq_seen;
  int            num_errors = 0;         // Mismatch count
  int            tests_run = 0;          // Comparison count
  int            seed;                   // Seed return value
  logic [31:0]   rd;                     // Last read data
  logic [1:0]    rs;                     // Last response
  logic [6:0]    en;                     // Event enables in use

  // Clock, 40 ns period
  always #20 clock = ~clock;

  // ==========================================================
  // Design and host model
  psi_top #(.NUM_EV(EV_COUNT)) DUT (
    .clock(clock), .rst(rst), .axil_req(req), .axil_rsp(rsp),
    .link_up(link_up), .duplex_full(duplex_full), .speed_10(speed_10), .an_complete(an_complete),
    .lq_evt(lq_evt), .energy_evt(energy_evt), .ctr_half_evt(ctr_half_evt),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq(irq), .powerdown(powerdown)
  );
  psi_host_model u_host (
    .clock(clock), .pin_o(pin_o), .pin_oe(pin_oe), .pd_req(pd_req), .pin_i(pin_i), .irq_seen(irq_seen)
  );

  // ==========================================================
  // Reporting
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare and count; four-state safe
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  // Bounded wait ran out
  task automatic tmo(input string n);
    $display("[ERR] %s expected handshake seen timeout", n);
    num_errors++;
    finish_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // ==========================================================
  // Bus tasks; an edge passes first so no signal is set twice at once
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w, ok;
    aw = 0; w = 0; ok = 0;
    @(posedge clock);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
    for (int n = 0; n < 100 && !ok; n++)
    begin
      @(posedge clock);
      if (!aw && rsp.awready)
      begin
        aw = 1; req.awvalid <= 1'b0;  // Address taken
      end
      if (!w && rsp.wready)
      begin
        w = 1; req.wvalid <= 1'b0;    // Data taken
      end
      if (rsp.bvalid)
      begin
        ok = 1; r = rsp.bresp; req.bready <= 1'b0;
      end
    end
    if (!ok) tmo("write");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, ok;
    ar = 0; ok = 0;
    @(posedge clock);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    for (int n = 0; n < 100 && !ok; n++)
    begin
      @(posedge clock);
      if (!ar && rsp.arready)
      begin
        ar = 1; req.arvalid <= 1'b0;  // Address taken
      end
      if (rsp.rvalid)
      begin
        ok = 1; d = rsp.rdata; r = rsp.rresp; req.rready <= 1'b0;
      end
    end
    if (!ok) tmo("read");
  endtask

  // Register access by index
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    axw({i, 2'h0}, d, rs);
    chk("wr_bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  task automatic rchk(input string n, input logic [5:0] i, input logic [31:0] e);
    axr({i, 2'h0}, rd, rs);
    chk(n, e, rd);
  endtask

  // Expected summary word from the live line status
  function automatic logic [31:0] sum_exp(input logic p);
    return {24'h0, p, 2'h0, an_complete, 1'h0, duplex_full, speed_10, link_up};
  endfunction

  // Raise event source i, in event bit order
  task automatic fire(input int i);
    @(posedge clock);
    case (i)
      0: ctr_half_evt <= 1'b1;
      1: an_complete <= 1'b1;         // Rising edge is the event
      2: duplex_full <= ~duplex_full;
      3: speed_10 <= ~speed_10;
      4: link_up <= ~link_up;
      5: energy_evt <= 1'b1;
      default: lq_evt <= 1'b1;
    endcase
    @(posedge clock);
    {ctr_half_evt, energy_evt, lq_evt} <= 3'h0;  // One-cycle pulses
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = $urandom(30);
    cyc(16);
    rst <= 1'b0;
    rchk("ctl_reset", IDX_CONTROL, 32'h0);
    rchk("evt_reset", IDX_EVENT, 32'h0);
    chk("irq_reset", 32'h0, irq);
    $display("Test reset done");

    // Random line status; a second read must not disturb the link copy
    // Host trusts speed and duplex only with link, so all are compared raw
    repeat (8)
    begin
      @(posedge clock);
      {link_up, duplex_full, speed_10, an_complete} <= 4'($urandom);
      cyc(2);
      rchk("summary", IDX_SUMMARY, sum_exp(1'b0));
      rchk("summary_again", IDX_SUMMARY, sum_exp(1'b0));
    end
    axr({IDX_EVENT, 2'h0}, rd, rs);
    $display("Test summary done");

    // Every control pattern with random reserved bits
    for (int i = 0; i < 8; i++)
    begin
      wr(IDX_CONTROL, {29'($urandom), 3'(i)});
      rchk("control", IDX_CONTROL, 32'(i));
      cyc(20);
      chk("test_irq", 32'(i >> 2), irq);
      chk("pin_drive", 32'((i >> 2) & i & 1), pin_oe);
      chk("pin_level", 32'h0, pin_o);
      chk("host_irq", 32'((i >> 2) & i & 1), irq_seen);
      rchk("summary_pend", IDX_SUMMARY, sum_exp(i[2]));
    end
    $display("Test control done");

    // Each source: gate off, enabled alone, masked
    for (int m = 0; m < 3; m++)
      for (int i = 0; i < 7; i++)
      begin
        en = (m == 1) ? 7'(1 << i) : (m == 2) ? (7'h7f ^ 7'(1 << i)) : 7'h7f;
        @(posedge clock);
        an_complete <= 1'b0;
        wr(IDX_EVENT, {25'h0, en});
        wr(IDX_CONTROL, (m == 0) ? 32'h1 : 32'h3);
        axr({IDX_EVENT, 2'h0}, rd, rs);
        fire(i);
        cyc(3);
        chk("event_irq", 32'(m == 1), irq);
        chk("host_irq", 32'(m == 1), irq_seen);
        rchk("summary_pend", IDX_SUMMARY, sum_exp(m == 1));
        rchk("event", IDX_EVENT, (32'h200 << i) | {25'h0, en});
        cyc(3);
        chk("irq_cleared", 32'h0, irq);
        rchk("event_cleared", IDX_EVENT, {25'h0, en});
      end
    $display("Test events done");

    // Pin as power-down input
    wr(IDX_CONTROL, 32'h0);
    @(posedge clock);
    pd_req <= 1'b1;
    cyc(6);
    chk("powerdown", 32'h1, powerdown);
    chk("pin_released", 32'h0, pin_oe);
    @(posedge clock);
    pd_req <= 1'b0;
    cyc(6);
    chk("powerdown_off", 32'h0, powerdown);
    $display("Test powerdown done");

    // Unmapped and read-only places
    axr(8'h4c, rd, rs);
    chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("unmapped_rdata", 32'h0, rd);
    axw(8'h4c, $urandom, rs);
    chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    axw({IDX_SUMMARY, 2'h0}, 32'hffff_ffff, rs);
    chk("summary_bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    rchk("summary_kept", IDX_SUMMARY, sum_exp(1'b0));
    $display("Test decode done");
    finish_test();
  end
endmodule // tb_phy_status_irq_control

`default_nettype wire
